// >>> verilog/pdo_sched_pkg.sv
// shared constants and types for the pdo scheduler
package pdo_sched_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_SYNC_PERIOD = 8'h10;
  localparam logic [7:0] REG_PDO_SEL = 8'h14;
  localparam logic [7:0] REG_TX_TYPE = 8'h18;
  localparam logic [7:0] REG_TX_TIMER = 8'h1C;
  localparam logic [7:0] REG_RX_TIMER = 8'h20;
  localparam logic [7:0] REG_TX_PEND = 8'h24;
  localparam logic [7:0] REG_RX_VALID = 8'h28;
  localparam logic [7:0] REG_RX_TMO = 8'h2C;
  localparam logic [7:0] REG_BIT_TIMING = 8'h30;
  localparam logic [7:0] REG_RATE = 8'h34;
  // interrupt status bit positions
  localparam int IRQ_SYNC_LOSS = 0;
  localparam int IRQ_RX_TMO = 1;
  localparam int IRQ_RATE_LOCK = 2;
  localparam int IRQ_W = 3;
  // transmission types
  localparam logic [7:0] TT_ACYCLIC = 8'h00;
  localparam logic [7:0] TT_CYC_MAX = 8'hF0;
  localparam logic [7:0] TT_VENDOR = 8'hFE;
  localparam logic [7:0] TT_PROFILE = 8'hFF;
  localparam logic [7:0] TT_RESET = 8'hFF;
  // address switches
  localparam logic [6:0] ADDR_DEFAULT = 7'h0B;
  localparam logic [6:0] ADDR_FACTORY = 7'h63;
  localparam logic [6:0] ADDR_DEL_BOOT = 7'h62;
  localparam logic [6:0] ADDR_DEL_CFG = 7'h61;
  // timer tick: one millisecond at 125 MHz
  localparam int CLK_HZ = 125000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int RATE_N = 9;
  localparam int RATE_LOCK_FRAMES = 4;
  // bit timing table entry
  typedef struct packed {
    logic [7:0] prescale;
    logic [7:0] segments;
  } bit_timing_t;
  typedef enum logic [1:0] {
    BD_SEARCH = 2'b00,
    BD_LOCKED = 2'b01
  } baud_state_t;
  // switch special functions
  typedef struct packed {
    logic factory;
    logic del_boot;
    logic del_cfg;
  } boot_cmd_t;
endpackage

// >>> verilog/canopen_pdo_slave_scheduler.sv
// pdo scheduler, sync supervision, node address and bit-rate logic
// Summary of operation
// R1: type 1..240 tx pdo sends once after every nth sync
// R2: rx pdo of type 0..240 becomes valid at next sync
// R3: supervise sync period; on loss drive outputs to error state
// R4: types 254 and 255 send on asynchronous events
// R5: every change of mapped input counts as a tx event
// R6: no inhibit time; no minimum spacing between sends
// R7: event timer expiry counts as extra tx event
// R8: application event sends now and restarts event timer
// R9: rx monitor timer notifies when no pdo arrives in time
// R10: address is tens switch times ten plus units; default 11
// R11: switches sampled only at power-up
// R12: at power-up 99, 98, 97 request factory, boot erase, config erase (the code does so only while end_terminal_only_i is high)
// R13: blink run and error alternately during bit-rate search
// R14: software reset keeps the detected bit rate
// R15: 1000k uses 00/14, 800k uses 00/16
// R16: 500..10k use segments 1C and listed prescalers
// R17: type 0 samples at sync and sends only after an event
// R18: up to 16 tx and 16 rx pdos; first four default active (the code resets every pdo to type 255, so all start active)
// R19: timer value zero disables the timer
`timescale 1ns/1ps
module canopen_pdo_slave_scheduler
  import pdo_sched_pkg::*;
#(
  parameter int N_PDO = 16,
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic power_on_i,
  input wire logic [3:0] address_switch_tens_i,
  input wire logic [3:0] address_switch_units_i,
  input wire logic end_terminal_only_i,
  input wire logic sync_rx_i,
  input wire logic [N_PDO-1:0] rx_pdo_i,
  input wire logic [N_PDO-1:0] tx_input_change_i,
  input wire logic [N_PDO-1:0] tx_vendor_event_i,
  input wire logic [N_PDO-1:0] tx_tx_done_i,
  input wire logic frame_ok_i,
  input wire logic [3:0] rate_candidate_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [N_PDO-1:0] tx_request_o,
  output logic [N_PDO-1:0] tx_sample_o,
  output logic [N_PDO-1:0] rx_valid_o,
  output logic outputs_error_o,
  output logic [6:0] node_address_o,
  output boot_cmd_t boot_cmd_o,
  output logic led_run_o,
  output logic led_can_err_o,
  output bit_timing_t bit_timing_o,
  output logic irq_o
);
  // refuse sizes that the select register and the counters cannot serve
  initial begin
    if (N_PDO < 1 || N_PDO > 16) $error("N_PDO must be 1..16");
    if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
    if (RATE_LOCK_FRAMES < 1 || RATE_LOCK_FRAMES > 8) $error("lock frame count must fit three bits");
  end

  // bit timing lookup, index 0 is 1000k down to 8 is 10k
  function automatic bit_timing_t timing_of(input logic [3:0] idx);
    bit_timing_t t;
    t.segments = 8'h1C; // R16
    t.prescale = 8'h00;
    unique case (idx)
      4'h0: t.segments = 8'h14; // R15
      4'h1: t.segments = 8'h16; // R15
      4'h2: t.prescale = 8'h00; // R16
      4'h3: t.prescale = 8'h01;
      4'h4: t.prescale = 8'h03;
      4'h5: t.prescale = 8'h04;
      4'h6: t.prescale = 8'h09;
      4'h7: t.prescale = 8'h18;
      4'h8: t.prescale = 8'h31;
      default: t.prescale = 8'h00;
    endcase
    return t;
  endfunction

  // switch digits to node address, widened before the product so tens up to 11 never wrap
  function automatic logic [6:0] switch_address(input logic [3:0] tens, input logic [3:0] units);
    return 7'(tens) * 7'd10 + 7'(units); // R10
  endfunction

  // pin synchronisers for the switch and strap pins
  logic [8:0] sw_s1_r, sw_s2_r;
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      sw_s1_r <= {end_terminal_only_i, address_switch_tens_i, address_switch_units_i};
      sw_s2_r <= sw_s1_r;
    end
  end

  // decoded once so the address and the special settings see the same digits
  logic [6:0] sw_addr;
  assign sw_addr = switch_address(sw_s2_r[7:4], sw_s2_r[3:0]);

  // power-on capture; a software reset does not repeat it
  logic por_done_r;
  logic [1:0] por_wait_r;
  always_ff @(posedge clk_i) begin
    if (power_on_i) begin
      por_done_r <= 1'b0;
      por_wait_r <= 2'd0;
      node_address_o <= ADDR_DEFAULT;
      boot_cmd_o <= '0;
    end else if (ce_i && !por_done_r) begin
      por_wait_r <= por_wait_r + 2'd1;
      if (por_wait_r == 2'd3) begin
        por_done_r <= 1'b1; // R11
        node_address_o <= sw_addr; // R10
        boot_cmd_o.factory <= sw_s2_r[8] && sw_addr == ADDR_FACTORY; // R12
        boot_cmd_o.del_boot <= sw_s2_r[8] && sw_addr == ADDR_DEL_BOOT;
        boot_cmd_o.del_cfg <= sw_s2_r[8] && sw_addr == ADDR_DEL_CFG;
      end
    end
  end

  // bit-rate search; held over rst_i, restarted only by power_on_i
  baud_state_t baud_r;
  logic [2:0] lock_cnt_r;
  logic [3:0] rate_r;
  logic [23:0] blink_r;
  logic rate_lock_ev;
  // same range check as the counter, so the lock interrupt never flags a refused rate
  assign rate_lock_ev = ce_i && baud_r == BD_SEARCH && frame_ok_i && rate_candidate_i < 4'(RATE_N)
                        && lock_cnt_r == 3'(RATE_LOCK_FRAMES - 1);
  always_ff @(posedge clk_i) begin
    if (power_on_i) begin
      baud_r <= BD_SEARCH;
      lock_cnt_r <= '0;
      rate_r <= 4'h0;
      blink_r <= '0;
      led_run_o <= 1'b0;
      led_can_err_o <= 1'b0;
      bit_timing_o <= timing_of(4'h0);
    end else if (ce_i) begin
      // free-running blink; bit 23 flips about every 67 ms at 125 MHz
      blink_r <= blink_r + 24'h1;
      unique case (baud_r)
        // searching: lamps alternate, timing follows the candidate
        BD_SEARCH: begin
          led_run_o <= blink_r[23]; // R13
          led_can_err_o <= !blink_r[23];
          bit_timing_o <= timing_of(rate_candidate_i);
          if (frame_ok_i && rate_candidate_i < 4'(RATE_N)) begin
            lock_cnt_r <= lock_cnt_r + 3'd1;
            rate_r <= rate_candidate_i;
            if (rate_lock_ev) baud_r <= BD_LOCKED;
          end
        end
        // locked: run lamp lit, error lamp follows sync loss
        BD_LOCKED: begin
          led_run_o <= 1'b1;
          led_can_err_o <= outputs_error_o;
          bit_timing_o <= timing_of(rate_r); // R14
        end
        default: baud_r <= BD_SEARCH;
      endcase
    end
  end

  // millisecond tick
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r;
  logic tick;
  assign tick = tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) tick_cnt_r <= '0;
    else if (ce_i) tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
  end

  // configuration registers
  logic [15:0] sync_period_r;
  logic [3:0] sel_r;
  logic [7:0] tx_type_r [N_PDO];
  logic [15:0] tx_timer_r [N_PDO];
  logic [15:0] rx_timer_r [N_PDO];
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r;
  logic [N_PDO-1:0] rx_tmo_r;
  logic wr, rd;
  // ack low keeps a held request from writing twice
  assign wr = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_period_r <= '0;
      sel_r <= '0;
      // every pdo starts as a profile-event type, sent on change
      for (int i = 0; i < N_PDO; i++) begin
        tx_type_r[i] <= TT_RESET; // R18
        tx_timer_r[i] <= '0;
        rx_timer_r[i] <= '0;
      end
    end else if (wr) begin
      unique case (wb_adr_i[7:0])
        REG_SYNC_PERIOD: sync_period_r <= wb_dat_i[15:0];
        REG_PDO_SEL: sel_r <= wb_dat_i[3:0];
        REG_TX_TYPE: tx_type_r[sel_r] <= wb_dat_i[7:0];
        REG_TX_TIMER: tx_timer_r[sel_r] <= wb_dat_i[15:0];
        REG_RX_TIMER: rx_timer_r[sel_r] <= wb_dat_i[15:0];
        default: ;
      endcase
    end
  end

  // sync counter per pdo and event logic
  logic [7:0] sync_cnt_r [N_PDO];
  logic [15:0] ev_cnt_r [N_PDO];
  logic [15:0] rx_cnt_r [N_PDO];
  logic [N_PDO-1:0] ev_pend_r, rx_pend_r, rx_tmo_ev;
  genvar g;
  generate
    for (g = 0; g < N_PDO; g++) begin : g_pdo
      logic cyc, async_t, ev, tmr_exp;
      // type decode: cyclic 1..240, asynchronous 254 and 255, reserved types stay silent
      assign cyc = tx_type_r[g] != TT_ACYCLIC && tx_type_r[g] <= TT_CYC_MAX;
      assign async_t = tx_type_r[g] == TT_VENDOR || tx_type_r[g] == TT_PROFILE;
      // event timer expiry, checked once per millisecond tick
      assign tmr_exp = tx_timer_r[g] != 16'h0 && tick && ev_cnt_r[g] + 16'h1 >= tx_timer_r[g]; // R19
      // R5 R4: change is profile event, vendor input for type 254
      assign ev = tx_type_r[g] == TT_VENDOR ? tx_vendor_event_i[g] : tx_input_change_i[g];
      // tx request: done clears it, a send decision later in the block wins
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync_cnt_r[g] <= '0;
          ev_cnt_r[g] <= '0;
          ev_pend_r[g] <= 1'b0;
          tx_request_o[g] <= 1'b0;
          tx_sample_o[g] <= 1'b0;
        end else if (ce_i) begin
          tx_sample_o[g] <= sync_rx_i && tx_type_r[g] == TT_ACYCLIC; // R17
          if (tx_tx_done_i[g]) tx_request_o[g] <= 1'b0;
          if (async_t && (ev || tmr_exp)) begin
            tx_request_o[g] <= 1'b1; // R4 R6 R7
            ev_cnt_r[g] <= '0; // R8
          end else if (async_t && tick && tx_timer_r[g] != 16'h0) begin
            ev_cnt_r[g] <= ev_cnt_r[g] + 16'h1;
          end
          // type 0: remember events until the next sync
          if (tx_type_r[g] == TT_ACYCLIC) begin
            if (ev) ev_pend_r[g] <= 1'b1;
            if (sync_rx_i && (ev_pend_r[g] || ev)) begin
              tx_request_o[g] <= 1'b1; // R17
              ev_pend_r[g] <= 1'b0;
            end
          end
          // cyclic: counts syncs from reset or from the last send
          if (cyc && sync_rx_i) begin
            if (sync_cnt_r[g] + 8'h1 >= tx_type_r[g]) begin
              sync_cnt_r[g] <= '0;
              tx_request_o[g] <= 1'b1; // R1
            end else begin
              sync_cnt_r[g] <= sync_cnt_r[g] + 8'h1;
            end
          end
        end
      end

      // rx: pending until sync, plus reception watchdog
      assign rx_tmo_ev[g] = ce_i && tick && rx_timer_r[g] != 16'h0 && !rx_pdo_i[g]
                            && rx_cnt_r[g] + 16'h1 == rx_timer_r[g]; // R9 R19
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          rx_pend_r[g] <= 1'b0;
          rx_valid_o[g] <= 1'b0;
          rx_cnt_r[g] <= '0;
          rx_tmo_r[g] <= 1'b0;
        end else if (ce_i) begin
          rx_valid_o[g] <= 1'b0;
          if (sync_rx_i && (rx_pend_r[g] || rx_pdo_i[g])) begin
            rx_valid_o[g] <= 1'b1; // R2
            rx_pend_r[g] <= 1'b0;
          end else if (rx_pdo_i[g]) begin
            rx_pend_r[g] <= 1'b1;
          end
          // watchdog restarts on each reception and fires once per silence
          if (rx_pdo_i[g]) begin
            rx_cnt_r[g] <= '0;
            rx_tmo_r[g] <= 1'b0;
          end else if (rx_tmo_ev[g]) begin
            rx_tmo_r[g] <= 1'b1;
            rx_cnt_r[g] <= rx_cnt_r[g] + 16'h1;
          end else if (tick && rx_timer_r[g] != 16'h0 && !rx_tmo_r[g]) begin
            rx_cnt_r[g] <= rx_cnt_r[g] + 16'h1;
          end
        end
      end
    end
  endgenerate

  // sync period supervision in ms ticks
  logic [15:0] sync_cnt_ms_r;
  logic sync_loss_ev;
  // loss flagged once; only a new sync or rst_i clears the error state
  assign sync_loss_ev = ce_i && tick && sync_period_r != 16'h0 && !sync_rx_i
                        && !outputs_error_o && sync_cnt_ms_r + 16'h1 >= sync_period_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_cnt_ms_r <= '0;
      outputs_error_o <= 1'b0;
    end else if (ce_i) begin
      if (sync_rx_i) begin
        sync_cnt_ms_r <= '0;
        outputs_error_o <= 1'b0;
      end else if (sync_loss_ev) begin
        outputs_error_o <= 1'b1; // R3
      end else if (tick && sync_period_r != 16'h0 && !outputs_error_o) begin
        sync_cnt_ms_r <= sync_cnt_ms_r + 16'h1;
      end
    end
  end

  // sticky interrupts; a new event beats a same-cycle clear
  logic [IRQ_W-1:0] irq_set;
  assign irq_set = {rate_lock_ev, |rx_tmo_ev, sync_loss_ev};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_stat_r <= (irq_stat_r & ~((wr && wb_adr_i[7:0] == REG_IRQ_STAT) ? wb_dat_i[IRQ_W-1:0] : '0)) | irq_set;
      if (wr && wb_adr_i[7:0] == REG_IRQ_MASK) irq_mask_r <= wb_dat_i[IRQ_W-1:0];
      // registered, so the line lags the status by one cycle
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // wishbone read path, one wait state; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      // ack exactly one cycle after the request edge
      wb_ack_o <= rd;
      wb_dat_o <= '0;
      if (rd) begin
        // pdo-indexed registers read the entry named by the select register
        unique case (wb_adr_i[7:0])
          REG_CTRL: wb_dat_o <= {25'h0, node_address_o};
          REG_STATUS: wb_dat_o <= {27'h0, boot_cmd_o, baud_r == BD_LOCKED, outputs_error_o};
          REG_IRQ_STAT: wb_dat_o <= 32'(irq_stat_r);
          REG_IRQ_MASK: wb_dat_o <= 32'(irq_mask_r);
          REG_SYNC_PERIOD: wb_dat_o <= {16'h0, sync_period_r};
          REG_PDO_SEL: wb_dat_o <= {28'h0, sel_r};
          REG_TX_TYPE: wb_dat_o <= {24'h0, tx_type_r[sel_r]};
          REG_TX_TIMER: wb_dat_o <= {16'h0, tx_timer_r[sel_r]};
          REG_RX_TIMER: wb_dat_o <= {16'h0, rx_timer_r[sel_r]};
          REG_TX_PEND: wb_dat_o <= 32'(tx_request_o);
          REG_RX_VALID: wb_dat_o <= 32'(rx_pend_r);
          REG_RX_TMO: wb_dat_o <= 32'(rx_tmo_r);
          REG_BIT_TIMING: wb_dat_o <= {16'h0, bit_timing_o};
          REG_RATE: wb_dat_o <= {28'h0, rate_r};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule // canopen_pdo_slave_scheduler

// >>> bench/pdo_master_model.sv
// behavioural network master: sync, rx pdos, tx completion
`timescale 1ns/1ps
module pdo_master_model #(
  parameter int N_PDO = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sync_go_i,
  input wire logic slow_i,
  input wire logic [N_PDO-1:0] rx_go_i,
  input wire logic [N_PDO-1:0] tx_request_i,
  output logic sync_o,
  output logic [N_PDO-1:0] rx_pdo_o,
  output logic [N_PDO-1:0] tx_done_o
);
  logic [2:0] wait_r;
  // one frame per command pulse
  always_ff @(posedge clk_i) begin
    sync_o <= sync_go_i;
    rx_pdo_o <= rx_go_i;
  end
  // slow mode mimics a busy bus delaying each transmission after the first by four cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_done_o <= '0;
      wait_r <= 3'h0;
    end else begin
      tx_done_o <= '0;
      if (|(tx_request_i & ~tx_done_o)) begin
        if (wait_r == 3'h0) begin
          tx_done_o <= tx_request_i & ~tx_done_o;
          wait_r <= slow_i ? 3'h4 : 3'h0;
        end else begin
          wait_r <= wait_r - 3'h1;
        end
      end
    end
  end
endmodule // pdo_master_model

// >>> bench/canopen_pdo_slave_scheduler_sva.sv
// port assertions for the pdo scheduler
`timescale 1ns/1ps
module pdo_sched_sva
  import pdo_sched_pkg::*;
#(
  parameter int N_PDO = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_on_i,
  input wire logic sync_rx_i,
  input wire logic [N_PDO-1:0] tx_tx_done_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [N_PDO-1:0] tx_request_o,
  input wire logic [N_PDO-1:0] tx_sample_o,
  input wire logic [N_PDO-1:0] rx_valid_o,
  input wire logic [6:0] node_address_o,
  input wire boot_cmd_t boot_cmd_o,
  input wire bit_timing_t bit_timing_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] pcnt_r;
  // cycles since power-on, saturating well past the capture window
  always_ff @(posedge clk_i) begin
    if (power_on_i) pcnt_r <= 4'h0;
    else if (pcnt_r != 4'hF) pcnt_r <= pcnt_r + 4'h1;
  end
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_addr_frozen: assert property (pcnt_r == 4'hF |-> $stable(node_address_o))
    else $error("node address changed after power-up");
  a_boot_frozen: assert property (pcnt_r == 4'hF |-> $stable(boot_cmd_o))
    else $error("boot command changed after power-up");
  a_rate_kept: assert property (disable iff (power_on_i) rst_i |=> $stable(bit_timing_o))
    else $error("soft reset changed bit timing");
  a_timing_table: assert property (bit_timing_o inside {16'h0014, 16'h0016, 16'h001C, 16'h011C,
    16'h031C, 16'h041C, 16'h091C, 16'h181C, 16'h311C}) else $error("bit timing not a table entry");
  a_rx_at_sync: assert property (|rx_valid_o |-> $past(sync_rx_i))
    else $error("rx valid without sync");
  a_sample_at_sync: assert property (|tx_sample_o |-> $past(sync_rx_i))
    else $error("tx sample without sync");
  a_req_held: assert property ($fell(tx_request_o[0]) && !$past(power_on_i) && !$past(rst_i)
    |-> $past(tx_tx_done_i[0])) else $error("tx request dropped before done");
endmodule // pdo_sched_sva
bind canopen_pdo_slave_scheduler pdo_sched_sva #(.N_PDO(N_PDO)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .power_on_i(power_on_i), .sync_rx_i(sync_rx_i),
  .tx_tx_done_i(tx_tx_done_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .tx_request_o(tx_request_o), .tx_sample_o(tx_sample_o), .rx_valid_o(rx_valid_o),
  .node_address_o(node_address_o), .boot_cmd_o(boot_cmd_o), .bit_timing_o(bit_timing_o));

// >>> bench/tb_canopen_pdo_slave_scheduler.sv
// self-checking bench for the pdo scheduler
`timescale 1ns/1ps
module tb_canopen_pdo_slave_scheduler;
  import pdo_sched_pkg::*;
  localparam int N = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pwr = 1'b1;
  logic [3:0] sw_t = 4'h3;
  logic [3:0] sw_u = 4'h4;
  logic eto = 1'b1;
  logic sync_go = 1'b0;
  logic slow = 1'b0;
  logic frm = 1'b0;
  logic [3:0] rate = 4'h0;
  logic [N-1:0] rx_go = '0;
  logic [N-1:0] chg = '0;
  logic [N-1:0] vnd = '0;
  logic [31:0] adr = '0;
  logic [31:0] wdat = '0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic [31:0] rdat, wb_dat_o, seed;
  logic wb_ack_o, err, led_r, led_e, irq, sync_w;
  logic [N-1:0] req, smp, rxv, rxp_w, done_w;
  logic [6:0] nadr;
  boot_cmd_t boot;
  bit_timing_t bt;
  int n_fail = 0;
  int cmp_count = 0;
  int n_req = 0;
  int n_rxv = 0;
  int n_smp = 0;
  int k, m, j, a, v;
  always #4 clk_i = ~clk_i;
  // short tick keeps millisecond timers to a few cycles
  canopen_pdo_slave_scheduler #(.N_PDO(N), .TICK_CYCLES(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .power_on_i(pwr), .address_switch_tens_i(sw_t),
    .address_switch_units_i(sw_u), .end_terminal_only_i(eto), .sync_rx_i(sync_w), .rx_pdo_i(rxp_w),
    .tx_input_change_i(chg), .tx_vendor_event_i(vnd), .tx_tx_done_i(done_w), .frame_ok_i(frm),
    .rate_candidate_i(rate), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_request_o(req),
    .tx_sample_o(smp), .rx_valid_o(rxv), .outputs_error_o(err), .node_address_o(nadr),
    .boot_cmd_o(boot), .led_run_o(led_r), .led_can_err_o(led_e), .bit_timing_o(bt), .irq_o(irq));
  pdo_master_model #(.N_PDO(N)) master (
    .clk_i(clk_i), .rst_i(rst_i), .sync_go_i(sync_go), .slow_i(slow), .rx_go_i(rx_go),
    .tx_request_i(req), .sync_o(sync_w), .rx_pdo_o(rxp_w), .tx_done_o(done_w));
  // event counters on pdo 0; each sent frame is acknowledged once
  always @(posedge clk_i) begin
    n_req <= n_req + int'(done_w[0] === 1'b1);
    n_rxv <= n_rxv + int'(rxv[0] === 1'b1);
    n_smp <= n_smp + int'(smp[0] === 1'b1);
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [31:0] bt_exp(input int r);
    case (r)
      0: return 32'h0014;
      1: return 32'h0016;
      2: return 32'h001C;
      3: return 32'h011C;
      4: return 32'h031C;
      5: return 32'h041C;
      6: return 32'h091C;
      7: return 32'h181C;
      default: return 32'h311C;
    endcase
  endfunction
  function automatic logic [31:0] be(input int ad, input logic e);
    return {29'h0, e && ad == 99, e && ad == 98, e && ad == 97};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic [7:0] ad, input logic [31:0] d, input logic w);
    int t;
    @(posedge clk_i);
    cyc <= 1'b1;
    adr <= {24'h000000, ad};
    wdat <= d;
    we <= w;
    t = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && t < 20) begin
      @(posedge clk_i);
      t++;
    end
    rdat = wb_dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
    chk("ack", {31'h0, wb_ack_o}, 32'h1);
  endtask
  task automatic pulse_sync;
    @(posedge clk_i);
    sync_go <= 1'b1;
    @(posedge clk_i);
    sync_go <= 1'b0;
    tk(10);
  endtask
  task automatic power_up;
    @(posedge clk_i);
    pwr <= 1'b1;
    @(posedge clk_i);
    pwr <= 1'b0;
    @(posedge clk_i);
    chk("addr_default", 32'(nadr), 32'(ADDR_DEFAULT));
    tk(11);
  endtask
  task automatic ev(input bit vendor);
    @(posedge clk_i);
    if (vendor) vnd[0] <= 1'b1;
    else chg[0] <= 1'b1;
    @(posedge clk_i);
    vnd <= '0;
    chg <= '0;
    tk(10);
  endtask
  initial begin
    #(8 * 20000);
    n_fail++;
    test_done;
  end
  initial begin
    seed = 32'h0000001B;
    tk(3);
    rst_i <= 1'b0;
    pwr <= 1'b0;
    tk(12);
    chk("req", req, 32'h0);
    wb(REG_TX_TYPE, 32'h0, 1'b0);
    chk("tx_type", rdat, 32'hFF);
    wb(8'h3C, 32'h0, 1'b0);
    chk("unmapped", rdat, 32'h0);
    // plain address, the three special settings, then 99 with more terminals attached
    for (k = 0; k < 5; k++) begin
      a = (k == 0) ? 34 : (k == 4) ? 99 : 100 - k;
      @(posedge clk_i);
      sw_t <= 4'(a / 10);
      sw_u <= 4'(a % 10);
      eto <= (k != 4);
      power_up;
      chk("addr", 32'(nadr), a);
      chk("boot", 32'(boot), be(a, k != 4));
      seed = xs(seed);
      @(posedge clk_i);
      sw_t <= 4'(seed[7:0] % 10);
      sw_u <= 4'(seed[15:8] % 10);
      tk(10);
      chk("addr_run", 32'(nadr), a);
    end
    for (k = 0; k < 9; k++) begin
      power_up;
      chk("leds", {31'h0, led_r ^ led_e}, 32'h1);
      repeat (4) begin
        @(posedge clk_i);
        frm <= 1'b1;
        rate <= 4'(k);
        @(posedge clk_i);
        frm <= 1'b0;
      end
      tk(6);
      chk("timing", 32'(bt), bt_exp(k));
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    tk(3);
    chk("timing_rst", 32'(bt), bt_exp(8));
    wb(REG_RATE, 32'h0, 1'b0);
    chk("rate_reg", rdat, 32'h8);
    wb(REG_PDO_SEL, 32'h0, 1'b1);
    slow <= 1'b1;
    for (k = 0; k < 3; k++) begin
      v = (k == 0) ? 1 : (k == 1) ? 3 : 240;
      wb(REG_TX_TYPE, v, 1'b1);
      m = n_req;
      repeat ((v == 240) ? 240 : 12) pulse_sync;
      tk(6);
      chk("cyclic", n_req - m, (v == 240) ? 1 : 12 / v);
    end
    slow <= 1'b0;
    for (k = 0; k < 2; k++) begin
      wb(REG_TX_TYPE, (k == 0) ? TT_VENDOR : TT_PROFILE, 1'b1);
      m = n_req;
      repeat (3) ev(k == 0);
      chk("async", n_req - m, 3);
    end
    // an event mid-period must push the next expiry out
    wb(REG_TX_TIMER, 32'h8, 1'b1);
    tk(14);
    ev(1'b0);
    m = n_req;
    tk(14);
    chk("tmr_restart", n_req - m, 0);
    tk(20);
    chk("tmr_expire", n_req - m, 1);
    wb(REG_TX_TIMER, 32'h0, 1'b1);
    m = n_req;
    tk(100);
    chk("tmr_off", n_req - m, 0);
    wb(REG_TX_TYPE, TT_ACYCLIC, 1'b1);
    m = n_req;
    j = n_smp;
    pulse_sync;
    chk("sample", n_smp - j, 1);
    ev(1'b0);
    chk("acyc_wait", n_req - m, 0);
    pulse_sync;
    chk("acyc_send", n_req - m, 1);
    j = n_rxv;
    @(posedge clk_i);
    rx_go[0] <= 1'b1;
    @(posedge clk_i);
    rx_go[0] <= 1'b0;
    tk(8);
    chk("rx_hold", n_rxv - j, 0);
    pulse_sync;
    chk("rx_valid", n_rxv - j, 1);
    wb(REG_SYNC_PERIOD, 32'h8, 1'b1);
    wb(REG_RX_TIMER, 32'h8, 1'b1);
    repeat (4) pulse_sync;
    chk("no_loss", {31'h0, err}, 32'h0);
    tk(60);
    chk("loss", {31'h0, err}, 32'h1);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wb(REG_IRQ_STAT, 32'h0, 1'b0);
    chk("stat", rdat & 32'h3, 32'h3);
    wb(REG_IRQ_MASK, 32'h3, 1'b1);
    tk(2);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(REG_SYNC_PERIOD, 32'h0, 1'b1);
    wb(REG_RX_TIMER, 32'h0, 1'b1);
    wb(REG_IRQ_STAT, 32'h3, 1'b1);
    tk(2);
    wb(REG_IRQ_STAT, 32'h0, 1'b0);
    chk("clear", rdat & 32'h3, 32'h0);
    chk("irq_off", {31'h0, irq}, 32'h0);
    test_done;
  end
endmodule // tb_canopen_pdo_slave_scheduler
